// [src/pdspc_pkg.sv]
package pdspc_pkg;

  // ****************************************
  // profile numbering and field layout
  // ****************************************
  localparam int unsigned PROFILE_W      = 3;
  localparam int unsigned FLAG_CNT       = 4;
  localparam logic [2:0]  PROFILE_FIRST  = 3'h2;
  localparam logic [2:0]  PROFILE_LAST   = 3'h5;
  localparam int unsigned STRAP_BIT      = 0;
  localparam logic        STRAP_RST      = 1'h0;

  // ****************************************
  // grouped carriers
  // ****************************************
  typedef struct packed {
    logic       sink_attached;
    logic       recovery_req;
    logic [2:0] profile;
  } pdspc_ctrl_t;

  typedef struct packed {
    logic bus_v_in_window;
    logic uv_en;
    logic uv_flag;
    logic ov_en;
    logic ov_flag;
  } pdspc_mon_t;

  typedef enum logic [2:0] {
    PDSPC_ST_IDLE     = 3'b001,
    PDSPC_ST_POWERED  = 3'b010,
    PDSPC_ST_RECOVERY = 3'b100
  } pdspc_state_t;

endpackage

// [src/pdspc_pin_ctrl.sv]
`timescale 1ns/10ps
module pdspc_pin_ctrl
  import pdspc_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire pdspc_ctrl_t i_ctrl,
  input  wire pdspc_mon_t  i_mon,
  input  wire logic        i_cc_term_req,
  input  wire logic        i_slave_address_strap,
  output logic             o_config_channel_a_pu,
  output logic             o_config_channel_b_pu,
  output logic             o_source_power_path_enable_n_o,
  output logic             o_source_power_path_enable_n_oe,
  output logic [3:0]       o_profile_select_flag_n_o,
  output logic [3:0]       o_profile_select_flag_n_oe,
  output logic             o_external_discharge_ctrl,
  output logic             o_internal_discharge,
  output logic             o_power_enable_status,
  output logic             o_slave_address_bit0,
  output logic             o_in_recovery
);

  // ****************************************
  // strap sync, three stages since it is a pin
  // ****************************************
  logic [2:0]   strap_sync;
  logic [2:0]   strap_fill;
  logic         strap_taken;
  pdspc_state_t state;
  pdspc_state_t next_state;
  logic         attached_q;
  logic         pwr_en;
  logic         disch;
  logic [3:0]   flags;
  logic [3:0]   flag_dec;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      strap_sync <= 3'h0;
    end else begin
      strap_sync <= {strap_sync[1:0], i_slave_address_strap};
    end
  end

  // fill marks stages that hold real pin samples; without it the
  // reset zeros of the chain would agree and be latched as the strap
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      strap_fill <= 3'h0;
    end else begin
      strap_fill <= {strap_fill[1:0], 1'h1};
    end
  end

  wire strap_agree = strap_fill[2] && (strap_sync[2] == strap_sync[1]);

  // latched at first agreeing sample after release, kept until next reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      strap_taken          <= 1'h0;
      o_slave_address_bit0 <= STRAP_RST;
    end else if (!strap_taken && strap_agree) begin
      strap_taken          <= 1'h1;
      o_slave_address_bit0 <= strap_sync[2];
    end
  end

  // ****************************************
  // qualification and state
  // ****************************************
  wire supply_ok = !(i_mon.uv_en && i_mon.uv_flag) && !(i_mon.ov_en && i_mon.ov_flag);
  wire power_ok  = i_ctrl.sink_attached && i_mon.bus_v_in_window && supply_ok;
  wire detach    = attached_q && !i_ctrl.sink_attached;
  wire window_lost = (state == PDSPC_ST_POWERED) && !i_mon.bus_v_in_window;

  always_comb begin
    next_state = state;
    case (state)
      PDSPC_ST_IDLE: begin
        if (power_ok) next_state = PDSPC_ST_POWERED;
      end
      PDSPC_ST_POWERED: begin
        if (window_lost || i_ctrl.recovery_req) next_state = PDSPC_ST_RECOVERY;
        else if (!power_ok) next_state = PDSPC_ST_IDLE;
      end
      PDSPC_ST_RECOVERY: begin
        // leave only once the sink has gone, avoids re-powering a faulty link
        if (!i_ctrl.sink_attached) next_state = PDSPC_ST_IDLE;
      end
      default: next_state = PDSPC_ST_IDLE;
    endcase
    if (state != PDSPC_ST_RECOVERY && i_ctrl.recovery_req) next_state = PDSPC_ST_RECOVERY;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state      <= PDSPC_ST_IDLE;
      attached_q <= 1'h0;
      pwr_en     <= 1'h0;
      disch      <= 1'h0;
      flags      <= 4'h0;
    end else begin
      state      <= next_state;
      attached_q <= i_ctrl.sink_attached;
      pwr_en     <= (next_state == PDSPC_ST_POWERED);
      disch      <= detach || (next_state == PDSPC_ST_RECOVERY);
      flags      <= i_ctrl.sink_attached ? flag_dec : 4'h0;
    end
  end

  // ****************************************
  // profile decode, one flag per profile 2 to 5, none for the others
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < FLAG_CNT; g++) begin : g_flag
      assign flag_dec[g] = (i_ctrl.profile == (PROFILE_FIRST + 3'(g)));
    end
  endgenerate

  // ****************************************
  // pins: open drain drives low only
  // ****************************************
  assign o_config_channel_a_pu            = i_resetn && i_cc_term_req;
  assign o_config_channel_b_pu            = i_resetn && i_cc_term_req;
  assign o_source_power_path_enable_n_o   = 1'h0;
  assign o_source_power_path_enable_n_oe  = pwr_en;
  assign o_power_enable_status            = !pwr_en; // pin level, low when on
  assign o_profile_select_flag_n_o        = 4'h0;
  assign o_profile_select_flag_n_oe       = flags;
  assign o_external_discharge_ctrl        = disch;
  assign o_internal_discharge             = disch;
  assign o_in_recovery                    = (state == PDSPC_ST_RECOVERY);

  // ****************************************
  // checks
  // ****************************************
  cc_float_a: assert property (@(posedge i_ref_clk)
    !i_resetn |->
    !o_config_channel_a_pu && !o_config_channel_b_pu)
    else $error("cc driven in reset");

  // enable is registered, so its qualification is looked at one edge back
  en_qual_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_source_power_path_enable_n_oe |->
    $past(i_ctrl.sink_attached) && $past(i_mon.bus_v_in_window))
    else $error("enable without qualification");
  en_od_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_source_power_path_enable_n_o == 1'h0)
    else $error("enable drives high");
  en_status_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_power_enable_status != o_source_power_path_enable_n_oe)
    else $error("status mismatch");
  supply_qual_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_mon.uv_en && i_mon.uv_flag) |=> !o_source_power_path_enable_n_oe)
    else $error("enable during undervoltage");
  ov_qual_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_mon.ov_en && i_mon.ov_flag) |=> !o_source_power_path_enable_n_oe)
    else $error("enable during overvoltage");

  strap_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !strap_fill[2] |-> !strap_taken)
    else $error("strap taken before sync filled");
  strap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    strap_taken && $past(strap_taken) |-> $stable(o_slave_address_bit0))
    else $error("strap changed");

  flag_onehot_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $onehot0(o_profile_select_flag_n_oe))
    else $error("flags not one-hot");
  flag_map_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_ctrl.sink_attached && (i_ctrl.profile >= PROFILE_FIRST) &&
    (i_ctrl.profile <= PROFILE_LAST) |=>
    o_profile_select_flag_n_oe == (4'h1 << ($past(i_ctrl.profile) - PROFILE_FIRST)))
    else $error("wrong profile flag");

  disch_mirror_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_external_discharge_ctrl == o_internal_discharge)
    else $error("discharge mismatch");
  detach_disch_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (attached_q && !i_ctrl.sink_attached) |=> o_external_discharge_ctrl)
    else $error("no discharge on detach");
  recov_disch_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_in_recovery |-> o_external_discharge_ctrl)
    else $error("no discharge in recovery");

  window_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == PDSPC_ST_POWERED && !i_mon.bus_v_in_window) |=>
    !o_source_power_path_enable_n_oe && o_in_recovery)
    else $error("no recovery");
  en_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_in_recovery |-> !o_source_power_path_enable_n_oe)
    else $error("enable held in recovery");

  idle_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !i_ctrl.sink_attached |=> o_profile_select_flag_n_oe == 4'h0)
    else $error("flag without sink");
  profile1_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_ctrl.profile < PROFILE_FIRST) |=> o_profile_select_flag_n_oe == 4'h0)
    else $error("flag for base profile");

  // ****************************************
  // cover points
  // ****************************************
  power_on_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(o_source_power_path_enable_n_oe));
  recovery_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) $rose(o_in_recovery));
  profile5_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_profile_select_flag_n_oe == 4'h8);
  detach_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $fell(i_ctrl.sink_attached) ##1 o_external_discharge_ctrl);
  strap_one_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(strap_taken) && o_slave_address_bit0);

endmodule

// [dv/pdspc_power_stage.sv]
`timescale 1ns/10ps
// ****************************************
// external switch gate and regulator select inputs
// ****************************************
module pdspc_power_stage (
  input  wire logic       i_en_o,
  input  wire logic       i_en_oe,
  input  wire logic [3:0] i_flag_o,
  input  wire logic [3:0] i_flag_oe,
  output logic            o_en_pin,
  output logic [3:0]      o_flag_pin
);
  // pull-ups lift every released pin, never a stale level
  assign o_en_pin   = i_en_oe ? i_en_o : 1'h1;
  assign o_flag_pin = ~i_flag_oe | i_flag_o;
endmodule

// [dv/test_pd_source_pin_control.sv]
`timescale 1ns/10ps
module test_pd_source_pin_control;
  import pdspc_pkg::*;
  // ****************************************
  // stimulus, instances and scenarios
  // ****************************************
  logic        ref_clk = 1'h0, resetn = 1'h0, cc_req = 1'h1, strap = 1'h1;
  pdspc_ctrl_t ctrl = '0;
  pdspc_mon_t  mon = '0;
  logic        pu_a, pu_b, en_o, en_oe, dis_ext, dis_int, status, slave_address_strap, in_rec, en_pin;
  logic [3:0]  fl_o, fl_oe, fl_pin;
  int          n_mismatch = 0, checks_done = 0;
  always #2 ref_clk = ~ref_clk;
  pdspc_pin_ctrl uut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_ctrl(ctrl), .i_mon(mon),
    .i_cc_term_req(cc_req), .i_slave_address_strap(strap), .o_config_channel_a_pu(pu_a),
    .o_config_channel_b_pu(pu_b), .o_source_power_path_enable_n_o(en_o),
    .o_source_power_path_enable_n_oe(en_oe), .o_profile_select_flag_n_o(fl_o),
    .o_profile_select_flag_n_oe(fl_oe), .o_external_discharge_ctrl(dis_ext),
    .o_internal_discharge(dis_int), .o_power_enable_status(status),
    .o_slave_address_bit0(slave_address_strap), .o_in_recovery(in_rec));
  pdspc_power_stage far (.i_en_o(en_o), .i_en_oe(en_oe), .i_flag_o(fl_o),
    .i_flag_oe(fl_oe), .o_en_pin(en_pin), .o_flag_pin(fl_pin));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic good(input logic [2:0] p);
    ctrl = '{1'h1, 1'h0, p};
    mon  = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};  // flags up but monitors disabled
  endtask
  task automatic t_reset();
    tick(2);
    chk({pu_a, pu_b, status}, 3'h1);
    tick(2);
    resetn = 1'h1;
    tick(6);
    chk({pu_a, pu_b, slave_address_strap}, 3'h7);
    strap = 1'h0;
    tick(6);
    chk(slave_address_strap, 1'h1);
  endtask
  task automatic t_qualify();
    for (int i = 0; i < 5; i++) begin
      ctrl.sink_attached = 1'h0;
      tick(2);
      good(3'h2);
      case (i)
        1: ctrl.sink_attached = 1'h0;
        2: mon.bus_v_in_window = 1'h0;
        3: mon.uv_en = 1'h1;
        4: mon.ov_en = 1'h1;
        default: ;
      endcase
      tick(2);
      chk({en_oe, status, en_pin}, (i == 0) ? 3'h4 : 3'h3);
    end
  endtask
  task automatic t_profile();
    for (int p = 1; p < 6; p++) begin
      good(3'(p));
      tick(2);
      chk(fl_pin, (p < 2) ? 4'hf : ~(4'h1 << (p - 2)));
    end
    ctrl.sink_attached = 1'h0;
    tick(1);
    chk(dis_ext, 1'h1);
    tick(1);
    chk(fl_pin, 4'hf);
  endtask
  task automatic t_recover(input logic by_req);
    good(3'h3);
    tick(2);
    if (by_req) ctrl.recovery_req = 1'h1;
    else mon.bus_v_in_window = 1'h0;
    tick(2);
    chk({en_oe, in_rec, dis_ext, dis_int}, 4'h7);
    good(3'h3);
    tick(2);
    chk({en_pin, in_rec}, 2'h3);
    ctrl.sink_attached = 1'h0;
    tick(1);
    chk({in_rec, dis_ext, dis_int}, 3'h3);
    tick(1);
    chk(dis_ext, 1'h0);
  endtask
  task automatic t_restart();
    good(3'h2);
    tick(2);
    resetn = 1'h0;
    strap = 1'h1;
    tick(1);
    chk({pu_a, pu_b, en_oe, slave_address_strap}, 4'h0);
    cc_req = 1'h0;
    tick(3);
    resetn = 1'h1;
    tick(6);
    chk({pu_a, pu_b, slave_address_strap, en_oe}, 4'h3);
    cc_req = 1'h1;
    tick(1);
    chk({pu_a, pu_b}, 2'h3);
  endtask
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_reset();
    t_qualify();
    t_profile();
    t_recover(1'h0);
    t_recover(1'h1);
    t_restart();
    finish_test();
  end
  // whole run needs well under 1 us
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
endmodule
